/* File: src/charger_option_consts.svh */
// Offsets, field positions, reset values and the write mask for the charger option word.
// Included by the option register module only; defines only.
`ifndef CHARGER_OPTION_CONSTS_SVH
`define CHARGER_OPTION_CONSTS_SVH
`define OPT_CMD_CODE 8'h12
`define OPT_BIT_FREQ_DIR 10
`define OPT_BIT_FREQ_EN 9
`define OPT_BIT_HS_FAULT 8
`define OPT_BIT_LS_FAULT 7
`define OPT_BIT_LEARN 6
`define OPT_BIT_MON_SEL 5
`define OPT_BIT_ADPT_PRES 4
`define OPT_BIT_AC_OCP 1
`define OPT_BIT_INHIBIT 0
`define OPT_LO_BITS 11
`define OPT_LO_RESET 11'h0102
`define OPT_WRITE_MASK 11'h07E3
`define OPT_DEPL_LSB 11
`define OPT_DEPL_MSB 12
`define OPT_DEPL_RESET 2'h2
`define OPT_UPPER_MSB 15
`define OPT_UPPER_RESET 3'h7
`endif

/* File: src/charger_option_pkg.sv */
// Types shared by the charger option block.
// Assumes the constants header is on the include path.
package charger_option_pkg;
   typedef enum logic [1:0]
   {
      LEARN_IDLE = 2'b00,
      LEARN_RUN = 2'b01,
      LEARN_END = 2'b11
   } learn_state_type;
   typedef logic [15:0] option_word_type;
endpackage

/* File: src/learn_ctrl_if.sv */
// Interface between the option register and the learn sequencer.
// Assumes one clock domain shared by both ends.
`timescale 1ns/10ps
interface learn_ctrl_if;
   logic learn_req;
   logic depleted;
   logic learn_done;
   logic run;
   modport regs (output learn_req, output depleted, input learn_done, input run);
   modport seq (input learn_req, input depleted, output learn_done, output run);
endinterface

/* File: src/learn_sequencer.sv */
// Learn cycle sequencer: swaps path switches while a learn cycle runs.
// Assumes depletion comes from the analogue comparator, already synchronous.
`timescale 1ns/10ps
module learn_sequencer
   import charger_option_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   learn_ctrl_if.seq lc
);
   learn_state_type state_q;
   learn_state_type state_d;
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         LEARN_IDLE:
            if (lc.learn_req)
               state_d = LEARN_RUN;
         LEARN_RUN:
            if (!lc.learn_req)
               state_d = LEARN_IDLE;
            else if (lc.depleted)
               state_d = LEARN_END;
         LEARN_END:
            state_d = LEARN_IDLE;
         default:
            state_d = LEARN_IDLE;
      endcase
   end
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         state_q <= LEARN_IDLE;
      else
         state_q <= state_d;
   end
   assign lc.run = (state_q == LEARN_RUN);
   // One-cycle pulse that tells the register to drop the learn bit
   assign lc.learn_done = (state_q == LEARN_END);
endmodule

/* File: src/charger_option_regs.sv */
// Charger option control word: low eleven option fields plus held upper fields.
// Assumes the bus front end delivers decoded word writes and read strobes.
//
// Overview of operation
// - Bit 10 picks the frequency shift direction, zero lowering by 18 percent and one raising, reset zero.
// - Bit 9 enables the frequency shift, zero meaning no adjustment, reset zero.
// - Bit 8 enables the high-side short comparator at 750mV when one, which is the reset value.
// - Bit 7 picks the low-side short threshold, zero for 135mV at reset and one for 230mV.
// - Writing one to bit 6 starts a learn cycle, opening the adapter switch and closing the battery switch.
// - When the battery reaches depletion the switches swap back and bit 6 clears itself.
// - Writing zero to bit 6 ends a learn cycle early and restores the adapter path.
// - Bit 5 routes the current monitor, zero adapter amplifier at reset and one charge amplifier.
// - Bit 4 is read-only adapter presence, and host writes to it are ignored.
// - Bit 1 enables adapter overcurrent protection at 3.33 times the limit, set at reset.
// - Bit 0 inhibits charging when one, and zero allows charging at reset.
`timescale 1ns/10ps
`include "charger_option_consts.svh"
module charger_option_regs
   import charger_option_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_bus_enable,
   input wire logic i_wr_stb,
   input wire logic [7:0] i_cmd,
   input wire logic [15:0] i_wr_data,
   input wire logic i_adapter_present,
   input wire logic i_battery_depleted,
   output logic [15:0] o_rd_data,
   output logic o_freq_shift_en,
   output logic o_freq_shift_up,
   output logic o_high_side_fault_compare_en,
   output logic o_low_side_fault_compare_high,
   output logic o_adapter_path_switch_on,
   output logic o_battery_path_switch_on,
   output logic o_current_monitor_output_sel,
   output logic o_adapter_overcurrent_protect_en,
   output logic o_charge_inhibit,
   output logic [1:0] o_depletion_sel
);
   logic [10:0] opt_q;
   logic [10:0] opt_d;
   logic [4:0] upper_q;
   logic [4:0] upper_d;
   logic pres_q;
   option_word_type word;
   wire write_hit;
   wire [10:0] wr_low;
   learn_ctrl_if lc ();

   learn_sequencer u_learn (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .lc(lc)
   );

   // Bus is dead when supply or adapter detect is too low
   assign write_hit = i_wr_stb && i_bus_enable && (i_cmd == `OPT_CMD_CODE);
   // Writes keep only the writable bits; presence and unused bits stay out
   assign wr_low = i_wr_data[10:0] & `OPT_WRITE_MASK;
   assign lc.learn_req = opt_q[`OPT_BIT_LEARN];
   assign lc.depleted = i_battery_depleted;

   always_comb
   begin
      opt_d = opt_q;
      upper_d = upper_q;
      if (write_hit)
      begin
         opt_d = wr_low;
         upper_d = i_wr_data[15:11];
      end
      else if (lc.learn_done)
         opt_d[`OPT_BIT_LEARN] = 1'b0;
   end

   // A host write in the same cycle as learn completion wins; it is the newer intent
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         opt_q <= `OPT_LO_RESET;
         upper_q <= {`OPT_UPPER_RESET, `OPT_DEPL_RESET};
         pres_q <= 1'b0;
      end
      else
      begin
         opt_q <= opt_d;
         upper_q <= upper_d;
         pres_q <= i_adapter_present;
      end
   end

   always_comb
   begin
      word = {upper_q, opt_q};
      word[`OPT_BIT_ADPT_PRES] = pres_q;
      word[3:2] = 2'b00;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_rd_data <= 16'h0000;
         o_freq_shift_en <= 1'b0;
         o_freq_shift_up <= 1'b0;
         o_high_side_fault_compare_en <= 1'b1;
         o_low_side_fault_compare_high <= 1'b0;
         o_adapter_path_switch_on <= 1'b1;
         o_battery_path_switch_on <= 1'b0;
         o_current_monitor_output_sel <= 1'b0;
         o_adapter_overcurrent_protect_en <= 1'b1;
         o_charge_inhibit <= 1'b0;
         o_depletion_sel <= `OPT_DEPL_RESET;
      end
      else
      begin
         o_rd_data <= word;
         o_freq_shift_en <= opt_q[`OPT_BIT_FREQ_EN];
         o_freq_shift_up <= opt_q[`OPT_BIT_FREQ_DIR];
         o_high_side_fault_compare_en <= opt_q[`OPT_BIT_HS_FAULT];
         o_low_side_fault_compare_high <= opt_q[`OPT_BIT_LS_FAULT];
         o_adapter_path_switch_on <= !lc.run;
         o_battery_path_switch_on <= lc.run;
         o_current_monitor_output_sel <= opt_q[`OPT_BIT_MON_SEL];
         o_adapter_overcurrent_protect_en <= opt_q[`OPT_BIT_AC_OCP];
         o_charge_inhibit <= opt_q[`OPT_BIT_INHIBIT];
         o_depletion_sel <= upper_q[1:0];
      end
   end

   sequence s_learn_start;
      write_hit && i_wr_data[`OPT_BIT_LEARN];
   endsequence
   sequence s_swap_on;
      ##2 o_battery_path_switch_on && !o_adapter_path_switch_on;
   endsequence
   sequence s_swap_back;
      ##2 o_adapter_path_switch_on && !o_battery_path_switch_on;
   endsequence

   a_learn_start_swap: assert property (@(posedge i_clk) disable iff (i_srst)
      s_learn_start ##1 (opt_q[`OPT_BIT_LEARN] && !i_battery_depleted && !write_hit && !lc.learn_done) |-> s_swap_on)
      else $error("learn start did not swap switches");
   a_learn_self_clear: assert property (@(posedge i_clk) disable iff (i_srst)
      lc.learn_done && !write_hit |=> !opt_q[`OPT_BIT_LEARN])
      else $error("learn bit not cleared at depletion");
   a_learn_abort: assert property (@(posedge i_clk) disable iff (i_srst)
      write_hit && !i_wr_data[`OPT_BIT_LEARN] |-> ##3 o_adapter_path_switch_on && !o_battery_path_switch_on)
      else $error("learn abort did not restore adapter path");
   a_switch_exclusive: assert property (@(posedge i_clk) disable iff (i_srst)
      o_adapter_path_switch_on != o_battery_path_switch_on)
      else $error("path switches not complementary");
   a_presence_ro: assert property (@(posedge i_clk) disable iff (i_srst)
      ##1 o_rd_data[`OPT_BIT_ADPT_PRES] == $past(pres_q))
      else $error("presence bit does not track input");
   a_unused_zero: assert property (@(posedge i_clk) disable iff (i_srst)
      o_rd_data[3:2] == 2'b00)
      else $error("unused bits read nonzero");
   a_freq_follow: assert property (@(posedge i_clk) disable iff (i_srst)
      write_hit |-> ##2 o_freq_shift_up == $past(i_wr_data[`OPT_BIT_FREQ_DIR], 2)
      && o_freq_shift_en == $past(i_wr_data[`OPT_BIT_FREQ_EN], 2))
      else $error("frequency controls did not follow write");
   a_fault_follow: assert property (@(posedge i_clk) disable iff (i_srst)
      write_hit |-> ##2 o_high_side_fault_compare_en == $past(i_wr_data[`OPT_BIT_HS_FAULT], 2)
      && o_low_side_fault_compare_high == $past(i_wr_data[`OPT_BIT_LS_FAULT], 2))
      else $error("fault thresholds did not follow write");
   a_misc_follow: assert property (@(posedge i_clk) disable iff (i_srst)
      write_hit |-> ##2 o_charge_inhibit == $past(i_wr_data[`OPT_BIT_INHIBIT], 2)
      && o_adapter_overcurrent_protect_en == $past(i_wr_data[`OPT_BIT_AC_OCP], 2)
      && o_current_monitor_output_sel == $past(i_wr_data[`OPT_BIT_MON_SEL], 2))
      else $error("option outputs did not follow write");
   a_bus_gated: assert property (@(posedge i_clk) disable iff (i_srst)
      i_wr_stb && !i_bus_enable && !lc.learn_done |=> $stable(opt_q))
      else $error("write taken while bus disabled");
   a_cmd_gate: assert property (@(posedge i_clk) disable iff (i_srst)
      i_wr_stb && (i_cmd != `OPT_CMD_CODE) && !lc.learn_done |=> $stable(opt_q) && $stable(upper_q))
      else $error("write to another command changed the word");
   a_unused_storage: assert property (@(posedge i_clk) disable iff (i_srst)
      opt_q[4:2] == 3'b000)
      else $error("read-only or unused bits stored a write");
   a_rd_follow: assert property (@(posedge i_clk) disable iff (i_srst)
      write_hit |-> ##2 o_rd_data[15:5] == $past(i_wr_data[15:5], 2)
      && o_rd_data[1:0] == $past(i_wr_data[1:0], 2))
      else $error("read word did not follow write");
   a_dep_follow: assert property (@(posedge i_clk) disable iff (i_srst)
      write_hit |-> ##2 o_depletion_sel == $past(i_wr_data[`OPT_DEPL_MSB:`OPT_DEPL_LSB], 2))
      else $error("depletion select did not follow write");

   // Learn sequencer handshake
   a_learn_end_swap: assert property (@(posedge i_clk) disable iff (i_srst)
      lc.run && lc.learn_req && i_battery_depleted |-> s_swap_back)
      else $error("depletion did not restore adapter path");
   a_done_pulse: assert property (@(posedge i_clk) disable iff (i_srst)
      lc.learn_done |=> !lc.learn_done)
      else $error("learn completion longer than one cycle");
   a_abort_idle: assert property (@(posedge i_clk) disable iff (i_srst)
      !lc.learn_req |=> !lc.run)
      else $error("learn kept running after bit cleared");
   a_run_needs_req: assert property (@(posedge i_clk) disable iff (i_srst)
      lc.run |-> $past(lc.learn_req))
      else $error("learn running without request");

   // Reset values, seen on the edge after any reset cycle; no disable here on purpose
   a_reset_freq: assert property (@(posedge i_clk)
      i_srst |=> !o_freq_shift_en && !o_freq_shift_up)
      else $error("frequency controls wrong after reset");
   a_reset_fields: assert property (@(posedge i_clk)
      i_srst |=> o_high_side_fault_compare_en && o_adapter_overcurrent_protect_en
      && !o_low_side_fault_compare_high)
      else $error("protection fields wrong after reset");
   a_reset_learn: assert property (@(posedge i_clk)
      i_srst |=> o_adapter_path_switch_on && !o_battery_path_switch_on && !opt_q[`OPT_BIT_LEARN])
      else $error("learn state wrong after reset");
   a_reset_misc: assert property (@(posedge i_clk)
      i_srst |=> !o_charge_inhibit && !o_current_monitor_output_sel
      && (o_depletion_sel == `OPT_DEPL_RESET))
      else $error("charge controls wrong after reset");
   a_reset_read: assert property (@(posedge i_clk)
      i_srst |=> o_rd_data == 16'h0000)
      else $error("read word not cleared in reset");
endmodule

/* File: verification/smbus_host_model.sv */
// Host model: delivers decoded word writes to the option block.
// Assumes the bench calls write_word from one process at a time.
`timescale 1ns/10ps
module smbus_host_model
(
   input wire logic i_clk,
   output logic o_bus_enable,
   output logic o_wr_stb,
   output logic [7:0] o_cmd,
   output logic [15:0] o_wr_data
);
   initial
   begin
      o_bus_enable = 1'b1;
      o_wr_stb = 1'b0;
      o_cmd = 8'h00;
      o_wr_data = 16'h0000;
   end
   // One whole word a strobe; en low models a bus that is not yet usable
   task automatic write_word(input logic [7:0] cmd, input logic [15:0] data, input logic en);
      @(posedge i_clk);
      o_bus_enable <= en;
      o_wr_stb <= 1'b1;
      o_cmd <= cmd;
      o_wr_data <= data;
      @(posedge i_clk);
      o_wr_stb <= 1'b0;
      o_bus_enable <= 1'b1;
      // Released lines show the inverse so stale data cannot pass for a match
      o_cmd <= ~cmd;
      o_wr_data <= ~data;
   endtask
endmodule

/* File: verification/tb_top.sv */
// Bench for the charger option word: random writes, refusals and learn cycles.
// Assumes the host model and the design share the one 200 MHz clock.
`timescale 1ns/10ps
module tb_top;
   import charger_option_pkg::*;
   logic i_clk, i_srst, i_adapter_present, i_battery_depleted;
   logic bus_en, wr_stb, f_en, f_up, hs, ls, sw_ac, sw_bat, mon, ocp, inh;
   logic [7:0] cmd;
   logic [15:0] wr_data;
   logic [1:0] dep_sel;
   option_word_type o_rd_data, exp_q;
   int mismatches = 0;
   int check_count = 0;
   smbus_host_model host_u (.i_clk(i_clk), .o_bus_enable(bus_en), .o_wr_stb(wr_stb), .o_cmd(cmd),
      .o_wr_data(wr_data));
   charger_option_regs dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_bus_enable(bus_en), .i_wr_stb(wr_stb),
      .i_cmd(cmd), .i_wr_data(wr_data), .i_adapter_present(i_adapter_present),
      .i_battery_depleted(i_battery_depleted), .o_rd_data(o_rd_data), .o_freq_shift_en(f_en),
      .o_freq_shift_up(f_up), .o_high_side_fault_compare_en(hs), .o_low_side_fault_compare_high(ls),
      .o_adapter_path_switch_on(sw_ac), .o_battery_path_switch_on(sw_bat),
      .o_current_monitor_output_sel(mon), .o_adapter_overcurrent_protect_en(ocp),
      .o_charge_inhibit(inh), .o_depletion_sel(dep_sel));
   initial
   begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
      check_count++;
      if (seen !== expv)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, expv, seen);
      end
   endtask
   task automatic stop_test();
      if (mismatches == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // Model word with presence merged in, compared against every output
   task automatic check_all();
      logic [15:0] w;
      w = exp_q;
      w[4] = i_adapter_present;
      check("rd_data", o_rd_data, w);
      check("fields", {7'h00, f_en, f_up, hs, ls, mon, ocp, inh, dep_sel},
         {7'h00, w[9], w[10], w[8], w[7], w[5], w[1], w[0], w[12:11]});
      check("switches", {14'h0000, sw_ac, sw_bat}, {14'h0000, !w[6], w[6]});
   endtask
   initial
   begin
      logic [15:0] d;
      logic [7:0] c;
      logic en;
      i_srst = 1'b1;
      i_adapter_present = 1'b0;
      i_battery_depleted = 1'b0;
      void'($urandom(32'h5b65_543a));
      repeat (8) @(posedge i_clk);
      i_srst <= 1'b0;
      tick(2);
      exp_q = 16'hf102;
      check_all();
      for (int k = 0; k < 16; k++)
      begin
         d = 16'($urandom);
         d[6] = 1'b0;
         c = ($urandom % 3 == 0) ? 8'h14 : 8'h12;
         en = ($urandom % 4 != 0);
         @(posedge i_clk);
         i_adapter_present <= 1'($urandom);
         host_u.write_word(c, d, en);
         // Other commands and writes with the bus disabled leave the word alone
         if (en && c == 8'h12)
            exp_q = d & 16'hffe3;
         tick(3);
         check_all();
      end
      for (int r = 0; r < 2; r++)
      begin
         d = exp_q | 16'h0040;
         host_u.write_word(8'h12, d, 1'b1);
         exp_q = d & 16'hffe3;
         tick(3);
         check_all();
         if (r == 0)
         begin
            @(posedge i_clk);
            i_battery_depleted <= 1'b1;
            for (int t = 0; t < 20 && sw_bat !== 1'b0; t++)
               tick(1);
            if (sw_bat !== 1'b0)
            begin
               check("learn_end_wait", {15'h0000, sw_bat}, 16'h0000);
               stop_test();
            end
            tick(2);
            exp_q[6] = 1'b0;
            check_all();
            @(posedge i_clk);
            i_battery_depleted <= 1'b0;
         end
         else
         begin
            exp_q[6] = 1'b0;
            host_u.write_word(8'h12, exp_q, 1'b1);
            tick(3);
            check_all();
         end
      end
      stop_test();
   end
endmodule
